/* File: hdl/asxc_pkg.sv */
package asxc_pkg;

	// register map, word index is the address
	localparam logic [3:0] ASXC_EXT0_ADDR   = 4'h0;
	localparam logic [3:0] ASXC_EXT1_ADDR   = 4'h1;
	localparam logic [3:0] ASXC_CTLB_ADDR   = 4'h2;
	localparam logic [3:0] ASXC_CTLA_ADDR   = 4'h3;
	localparam logic [3:0] ASXC_TCL_ADDR    = 4'h4;
	localparam logic [3:0] ASXC_TCH_ADDR    = 4'h5;
	localparam logic [3:0] ASXC_STAT0_ADDR  = 4'h6;
	localparam logic [3:0] ASXC_IRQST_ADDR  = 4'h7;
	localparam logic [3:0] ASXC_IRQEN_ADDR  = 4'h8;
	localparam logic [3:0] ASXC_IRQCLR_ADDR = 4'h9;
	localparam logic [3:0] ASXC_IOCTL_ADDR  = 4'hA;

	// extension control fields
	localparam int ASXC_SBRK_BIT = 0;
	localparam int ASXC_BDET_BIT = 1;
	localparam int ASXC_BEN_BIT  = 2;
	localparam int ASXC_BRGM_BIT = 3;
	localparam int ASXC_X1_BIT   = 4;
	localparam int ASXC_CTSD_BIT = 5;
	localparam int ASXC_DCDD_BIT = 6;
	localparam logic [7:0] ASXC_EXT_RST  = 8'h00;
	localparam logic [7:0] ASXC_EXT_WMSK0 = 8'h7D;
	localparam logic [7:0] ASXC_EXT_WMSK1 = 8'h1D;

	// control b fields: speed select [2:0], divide ratio [3], prescale [5], cts level [6]
	localparam int ASXC_DR_BIT  = 3;
	localparam int ASXC_PS_BIT  = 5;
	localparam int ASXC_CTS_BIT = 6;
	localparam logic [2:0] ASXC_SS_EXT = 3'h7;
	localparam logic [7:0] ASXC_CTLB_RST = 8'h00;
	// control a: error flag reset at bit 3, write 0 clears
	localparam int ASXC_EFR_BIT = 3;
	// status bits: tx empty [1], dcd level [2]
	localparam int ASXC_TX_DATA_EMPTY_FLAG_BIT = 1;
	localparam int ASXC_DCD_BIT  = 2;
	// interrupt bits: dcd rise [0], break detect ch0 [1], break detect ch1 [2]
	localparam int ASXC_NIRQ = 3;

	localparam logic [17:0] ASXC_DIV_LO = 18'h0000A;
	localparam logic [17:0] ASXC_DIV_HI = 18'h0001E;
	localparam logic [5:0]  ASXC_OVS_LO = 6'h0F;
	localparam logic [5:0]  ASXC_OVS_HI = 6'h3F;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} asxc_bus_t;

	typedef struct packed {
		logic       rx_char_valid;
		logic [7:0] rx_char;
		logic       rx_frame_err;
	} asxc_rxev_t;

endpackage

/* File: hdl/asxc_top.sv */
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
module asxc_top
	import asxc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       carrier_detect_input,
	input  wire logic       clear_to_send_input,
	input  wire logic       serial_clock_pin_in,
	input  wire logic       tx_serial_data,
	input  wire logic       tx_holding_empty,
	input  wire logic [1:0] rx_char_valid,
	input  wire logic [15:0] rx_char,
	input  wire logic [1:0] rx_frame_err,
	output logic      [1:0] serial_tx_pin,
	output logic      [1:0] rx_hold_reset,
	output logic      [1:0] bit_clk_en,
	output logic      [1:0] serial_clock_pin_out,
	output logic            irq
);

	asxc_bus_t  bus;
	logic [7:0] ext_r [2];
	logic [7:0] ctlb_r;
	logic [15:0] tc_r;
	logic       io_halt_mode_r;
	logic [ASXC_NIRQ-1:0] ist_r;
	logic [ASXC_NIRQ-1:0] ien_r;
	logic [1:0] dcd_s_r;
	logic [1:0] cts_s_r;
	logic [1:0] ck_s_r;
	logic       dcd_d_r;
	logic       ck_d_r;
	logic [17:0] brg_cnt_r;
	logic       brg_tick;
	logic [17:0] brg_div;
	logic [5:0] ovs_cnt_r;
	logic       base_tick;
	logic       dcd_hold;
	logic       efr_clr;
	logic       dcd_rise;
	logic [1:0] bdet_set;
	logic [7:0] rdata_nxt;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign efr_clr = bus.wr && bus.addr == ASXC_CTLA_ADDR && !bus.wdata[ASXC_EFR_BIT];

	// synchronisers for pins
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dcd_s_r <= 2'h3;
			cts_s_r <= 2'h3;
			ck_s_r  <= 2'h0;
			dcd_d_r <= 1'h1;
			ck_d_r  <= 1'h0;
		end
		else
		begin
			dcd_s_r <= {dcd_s_r[0], carrier_detect_input};
			cts_s_r <= {cts_s_r[0], clear_to_send_input};
			ck_s_r  <= {ck_s_r[0], serial_clock_pin_in};
			dcd_d_r <= dcd_s_r[1];
			ck_d_r  <= ck_s_r[1];
		end
	end

	assign dcd_rise = dcd_s_r[1] && !dcd_d_r;
	assign dcd_hold = !ext_r[0][ASXC_DCDD_BIT] && dcd_s_r[1];

	// register writes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_r[0]       <= ASXC_EXT_RST;
			ext_r[1]       <= ASXC_EXT_RST;
			ctlb_r         <= ASXC_CTLB_RST;
			tc_r           <= 16'h0000;
			io_halt_mode_r <= 1'h0;
			ien_r          <= '0;
		end
		else
		begin
			if (bus.wr && bus.addr == ASXC_CTLB_ADDR)
				ctlb_r <= bus.wdata;
			if (bus.wr && bus.addr == ASXC_TCL_ADDR)
				tc_r[7:0] <= bus.wdata;
			if (bus.wr && bus.addr == ASXC_TCH_ADDR)
				tc_r[15:8] <= bus.wdata;
			if (bus.wr && bus.addr == ASXC_IOCTL_ADDR)
				io_halt_mode_r <= bus.wdata[0];
			if (bus.wr && bus.addr == ASXC_IRQEN_ADDR)
				ien_r <= bus.wdata[ASXC_NIRQ-1:0];
			for (int c = 0; c < 2; c++)
			begin
				// break detect is read-only; set wins over clear
				if (bdet_set[c])
					ext_r[c][ASXC_BDET_BIT] <= 1'h1;
				else if (efr_clr || io_halt_mode_r || (c == 0 && dcd_hold))
					ext_r[c][ASXC_BDET_BIT] <= 1'h0;
				if (bus.wr && bus.addr == (c == 0 ? ASXC_EXT0_ADDR : ASXC_EXT1_ADDR))
				begin
					for (int b = 0; b < 8; b++)
						if ((c == 0 ? ASXC_EXT_WMSK0[b] : ASXC_EXT_WMSK1[b]))
							ext_r[c][b] <= bus.wdata[b];
				end
			end
		end
	end

	// break detection needs break enable and a live receiver
	assign bdet_set[0] = ext_r[0][ASXC_BEN_BIT] && rx_char_valid[0] && !dcd_hold
		&& rx_char[7:0] == 8'h00 && rx_frame_err[0];
	assign bdet_set[1] = ext_r[1][ASXC_BEN_BIT] && rx_char_valid[1]
		&& rx_char[15:8] == 8'h00 && rx_frame_err[1];

	// interrupt status, set beats clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ist_r <= '0;
		else
		begin
			for (int i = 0; i < ASXC_NIRQ; i++)
			begin
				if ((i == 0 && dcd_rise) || (i > 0 && bdet_set[i-1]))
					ist_r[i] <= 1'h1;
				else if (bus.wr && bus.addr == ASXC_IRQCLR_ADDR && bus.wdata[i])
					ist_r[i] <= 1'h0;
			end
		end
	end

	// shared baud divider, channel 0 settings; ch1 reuses it for simplicity
	always_comb
	begin
		if (ext_r[0][ASXC_BRGM_BIT])
			brg_div = {1'b0, tc_r, 1'b0} + 18'h00004;
		else
			brg_div = (ctlb_r[ASXC_PS_BIT] ? ASXC_DIV_HI : ASXC_DIV_LO)
				<< ctlb_r[2:0];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			brg_cnt_r <= 18'h00000;
		else if (brg_tick)
			brg_cnt_r <= 18'h00000;
		else
			brg_cnt_r <= brg_cnt_r + 18'h00001;
	end

	assign brg_tick = brg_cnt_r + 18'h00001 >= brg_div;
	// speed select 111 takes the external clock rising edge
	assign base_tick = (ctlb_r[2:0] == ASXC_SS_EXT) ? (ck_s_r[1] && !ck_d_r) : brg_tick;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ovs_cnt_r <= 6'h00;
		else if (base_tick)
		begin
			if (ovs_cnt_r == (ctlb_r[ASXC_DR_BIT] ? ASXC_OVS_HI : ASXC_OVS_LO))
				ovs_cnt_r <= 6'h00;
			else
				ovs_cnt_r <= ovs_cnt_r + 6'h01;
		end
	end

	// outputs, all registered
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serial_tx_pin        <= 2'h3;
			rx_hold_reset        <= 2'h0;
			bit_clk_en           <= 2'h0;
			serial_clock_pin_out <= 2'h0;
			irq                  <= 1'h0;
			rdata                <= 8'h00;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (ext_r[c][ASXC_BEN_BIT] && ext_r[c][ASXC_SBRK_BIT])
					serial_tx_pin[c] <= 1'h0;
				else
					serial_tx_pin[c] <= tx_serial_data;
				if (ext_r[c][ASXC_X1_BIT])
					bit_clk_en[c] <= base_tick;
				else
					bit_clk_en[c] <= base_tick && ovs_cnt_r == 6'h00;
				// high for the second half of each period, so the pin runs at the divider rate
				serial_clock_pin_out[c] <= brg_cnt_r >= (brg_div >> 1);
			end
			rx_hold_reset <= {1'h0, dcd_hold};
			irq   <= |(ist_r & ien_r);
			rdata <= rdata_nxt;
		end
	end

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (bus.rd)
		begin
			unique case (bus.addr)
				ASXC_EXT0_ADDR:  rdata_nxt = ext_r[0] & 8'h7F;
				ASXC_EXT1_ADDR:  rdata_nxt = ext_r[1] & 8'h1F;
				ASXC_CTLB_ADDR:  rdata_nxt = {ctlb_r[7], cts_s_r[1], ctlb_r[5:0]};
				ASXC_TCL_ADDR:   rdata_nxt = tc_r[7:0];
				ASXC_TCH_ADDR:   rdata_nxt = tc_r[15:8];
				ASXC_STAT0_ADDR: rdata_nxt = {5'h00, dcd_s_r[1],
					tx_holding_empty && !(!ext_r[0][ASXC_CTSD_BIT] && cts_s_r[1]), 1'h0};
				ASXC_IRQST_ADDR: rdata_nxt = {5'h00, ist_r};
				ASXC_IRQEN_ADDR: rdata_nxt = {5'h00, ien_r};
				ASXC_IOCTL_ADDR: rdata_nxt = {7'h00, io_halt_mode_r};
				default:         rdata_nxt = 8'h00;
			endcase
		end
	end

	property p_break_tx;
		@(posedge clk) disable iff (!rstn)
		(ext_r[0][ASXC_BEN_BIT] && ext_r[0][ASXC_SBRK_BIT]) |=> !serial_tx_pin[0];
	endproperty
	a_break_tx: assert property (p_break_tx) else $error("tx not held low");

	property p_dcd_hold;
		@(posedge clk) disable iff (!rstn)
		(!ext_r[0][ASXC_DCDD_BIT] && dcd_s_r[1]) |=> rx_hold_reset[0];
	endproperty
	a_dcd_hold: assert property (p_dcd_hold) else $error("receiver not held");

	property p_dcd_free;
		@(posedge clk) disable iff (!rstn)
		ext_r[0][ASXC_DCDD_BIT] |=> !rx_hold_reset[0];
	endproperty
	a_dcd_free: assert property (p_dcd_free) else $error("dcd affects rx");

	property p_bdet;
		@(posedge clk) disable iff (!rstn)
		bdet_set[0] |=> ext_r[0][ASXC_BDET_BIT];
	endproperty
	a_bdet: assert property (p_bdet) else $error("break not detected");

	property p_bdet_clr;
		@(posedge clk) disable iff (!rstn)
		(efr_clr && !bdet_set[1]) |=> !ext_r[1][ASXC_BDET_BIT];
	endproperty
	a_bdet_clr: assert property (p_bdet_clr) else $error("break not cleared");

	property p_no_ben;
		@(posedge clk) disable iff (!rstn)
		(!ext_r[1][ASXC_BEN_BIT] && !ext_r[1][ASXC_BDET_BIT]) |=> !ext_r[1][ASXC_BDET_BIT];
	endproperty
	a_no_ben: assert property (p_no_ben) else $error("break w/o enable");

	property p_cts;
		@(posedge clk) disable iff (!rstn)
		(bus.rd && bus.addr == ASXC_STAT0_ADDR && !ext_r[0][ASXC_CTSD_BIT] && cts_s_r[1])
			|=> !rdata[ASXC_TX_DATA_EMPTY_FLAG_BIT];
	endproperty
	a_cts: assert property (p_cts) else $error("tx_data_empty_flag not forced");

	property p_rsv;
		@(posedge clk) disable iff (!rstn)
		(bus.rd && bus.addr == ASXC_EXT1_ADDR) |=> rdata[7:5] == 3'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");

	c_break: cover property (@(posedge clk) disable iff (!rstn) bdet_set[0]);
	c_dcd:   cover property (@(posedge clk) disable iff (!rstn) dcd_rise);
	c_irq:   cover property (@(posedge clk) disable iff (!rstn) irq);
	c_sbrk:  cover property (@(posedge clk) disable iff (!rstn) !serial_tx_pin[0]);
	c_hold:  cover property (@(posedge clk) disable iff (!rstn) rx_hold_reset[0]);

	property p_break_tx1;
		@(posedge clk) disable iff (!rstn)
		(ext_r[1][ASXC_BEN_BIT] && ext_r[1][ASXC_SBRK_BIT]) |=> !serial_tx_pin[1];
	endproperty
	a_break_tx1: assert property (p_break_tx1) else $error("tx1 not held low");

	property p_tx_pass;
		@(posedge clk) disable iff (!rstn)
		!(ext_r[0][ASXC_BEN_BIT] && ext_r[0][ASXC_SBRK_BIT])
			|=> serial_tx_pin[0] == $past(tx_serial_data);
	endproperty
	a_tx_pass: assert property (p_tx_pass) else $error("tx stream lost");

	property p_irq_on;
		@(posedge clk) disable iff (!rstn)
		(|(ist_r & ien_r)) |=> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");

	property p_irq_off;
		@(posedge clk) disable iff (!rstn)
		!(|(ist_r & ien_r)) |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without cause");

	property p_dcd_ist;
		@(posedge clk) disable iff (!rstn)
		dcd_rise |=> ist_r[0];
	endproperty
	a_dcd_ist: assert property (p_dcd_ist) else $error("dcd edge not flagged");

	property p_x1_clk;
		@(posedge clk) disable iff (!rstn)
		(ext_r[0][ASXC_X1_BIT] && base_tick) |=> bit_clk_en[0];
	endproperty
	a_x1_clk: assert property (p_x1_clk) else $error("x1 tick lost");

	property p_ovs_gap;
		@(posedge clk) disable iff (!rstn)
		(!ext_r[0][ASXC_X1_BIT] && ovs_cnt_r != 6'h00) |=> !bit_clk_en[0];
	endproperty
	a_ovs_gap: assert property (p_ovs_gap) else $error("bit clock not divided");

	property p_ck_pin;
		@(posedge clk) disable iff (!rstn)
		(brg_tick && brg_div > 18'h00001) |=> serial_clock_pin_out[0];
	endproperty
	a_ck_pin: assert property (p_ck_pin) else $error("clock pin low at tick");

	property p_cts_free;
		@(posedge clk) disable iff (!rstn)
		(bus.rd && bus.addr == ASXC_STAT0_ADDR && ext_r[0][ASXC_CTSD_BIT]
			&& tx_holding_empty) |=> rdata[ASXC_TX_DATA_EMPTY_FLAG_BIT];
	endproperty
	a_cts_free: assert property (p_cts_free) else $error("cts not ignored");

	property p_efr_clr0;
		@(posedge clk) disable iff (!rstn)
		(efr_clr && !bdet_set[0]) |=> !ext_r[0][ASXC_BDET_BIT];
	endproperty
	a_efr_clr0: assert property (p_efr_clr0) else $error("break0 not cleared");

	property p_dcd_bdet;
		@(posedge clk) disable iff (!rstn)
		dcd_hold |=> !ext_r[0][ASXC_BDET_BIT];
	endproperty
	a_dcd_bdet: assert property (p_dcd_bdet) else $error("break kept on dcd");

	property p_halt_clr;
		@(posedge clk) disable iff (!rstn)
		(io_halt_mode_r && !bdet_set[0]) |=> !ext_r[0][ASXC_BDET_BIT];
	endproperty
	a_halt_clr: assert property (p_halt_clr) else $error("break kept in halt");

	property p_rsv0;
		@(posedge clk) disable iff (!rstn)
		(bus.rd && bus.addr == ASXC_EXT0_ADDR) |=> !rdata[7];
	endproperty
	a_rsv0: assert property (p_rsv0) else $error("bit 7 set");

endmodule

/* File: tb/asxc_remote.sv */
`timescale 1ns/10ps
module asxc_remote (
	input  wire logic	clk,
	input  wire logic	dcd_neg,
	input  wire logic	cts_neg,
	input  wire logic	ck_run,
	output logic		carrier_detect_input,
	output logic		clear_to_send_input,
	output logic		serial_clock_pin_in
);
	logic [2:0]	ck_cnt_r = 3'h0;
	// modem lines move just after a clk edge, in step with the block's own sampling clock
	always @(posedge clk)
	begin
		carrier_detect_input <= dcd_neg;
		clear_to_send_input  <= cts_neg;
	end
	// external bit clock, eight cycles a period, stands still unless a test runs it
	always @(posedge clk)
	begin
		if (ck_run)
			ck_cnt_r <= ck_cnt_r + 3'h1;
	end
	assign serial_clock_pin_in = ck_cnt_r[2];
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import asxc_pkg::*;
	logic		clk = 1'b0;
	logic		rstn = 1'b0;
	logic [3:0]	addr = 4'h0;
	logic [7:0]	wdata = 8'h00;
	logic		wr = 1'b0;
	logic		rd = 1'b0;
	logic		dcd_neg = 1'b0;
	logic		cts_neg = 1'b0;
	logic		ck_run = 1'b0;
	logic		tx_serial_data = 1'b1;
	logic		tx_holding_empty = 1'b1;
	logic [1:0]	rx_char_valid = 2'h0;
	logic [15:0]	rx_char = 16'h0000;
	logic [1:0]	rx_frame_err = 2'h0;
	logic [7:0]	rdata;
	logic		cdi;
	logic		ctsi;
	logic		sck;
	logic [1:0]	serial_tx_pin;
	logic [1:0]	rx_hold_reset;
	logic [1:0]	bit_clk_en;
	logic [1:0]	sck_out;
	logic		irq;
	int		error_cnt = 0;
	int		samples_checked = 0;
	int		cyc = 0;

	asxc_remote u_asxc_remote (.clk(clk), .dcd_neg(dcd_neg), .cts_neg(cts_neg),
		.ck_run(ck_run),
		.carrier_detect_input(cdi), .clear_to_send_input(ctsi), .serial_clock_pin_in(sck));
	asxc_top u_asxc_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .carrier_detect_input(cdi), .clear_to_send_input(ctsi),
		.serial_clock_pin_in(sck), .tx_serial_data(tx_serial_data),
		.tx_holding_empty(tx_holding_empty), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .rx_frame_err(rx_frame_err), .serial_tx_pin(serial_tx_pin),
		.rx_hold_reset(rx_hold_reset), .bit_clk_en(bit_clk_en),
		.serial_clock_pin_out(sck_out), .irq(irq));

	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// longest case is a few hundred cycles per baud period
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// first loop aligns on a tick, second measures one full period
	task automatic baud(input logic [7:0] x, input logic [7:0] b, input logic [15:0] tc,
		input logic [17:0] e);
		int n;
		wreg(ASXC_EXT0_ADDR, x);
		wreg(ASXC_CTLB_ADDR, b);
		wreg(ASXC_TCL_ADDR, tc[7:0]);
		wreg(ASXC_TCH_ADDR, tc[15:8]);
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				#1 n++;
			end while (bit_clk_en[0] !== 1'b1 && n < 3000);
		end
		chk(18'(n), e);
	endtask

	// clock pin period from one rising edge to the next
	task automatic ckpin(input logic [17:0] e);
		time t0;
		@(posedge sck_out[0]);
		t0 = $time;
		@(posedge sck_out[0]);
		chk(18'(($time - t0) / 64'd10), e);
	endtask

	task automatic brk_event(input logic [1:0] ch, input logic [15:0] d);
		@(posedge clk);
		rx_char_valid <= ch;
		rx_frame_err <= ch;
		rx_char <= d;
		@(posedge clk);
		rx_char_valid <= 2'h0;
		rx_frame_err <= 2'h0;
		rx_char <= 16'h0000;
		wait_n(2);
	endtask

	task automatic t_regs;
		rreg(ASXC_EXT0_ADDR, 8'h00);
		rreg(ASXC_EXT1_ADDR, 8'h00);
		chk(serial_tx_pin, 2'h3);
		wreg(ASXC_EXT0_ADDR, 8'hFF);
		rreg(ASXC_EXT0_ADDR, 8'h7D);
		wreg(ASXC_EXT1_ADDR, 8'hFF);
		rreg(ASXC_EXT1_ADDR, 8'h1D);
		rreg(4'hF, 8'h00);
		wreg(ASXC_EXT0_ADDR, 8'h00);
		wreg(ASXC_EXT1_ADDR, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_modem;
		wreg(ASXC_IRQEN_ADDR, 8'h01);
		@(posedge clk);
		dcd_neg <= 1'b1;
		wait_n(6);
		chk(rx_hold_reset, 2'h1);
		rreg(ASXC_STAT0_ADDR, 8'h06);
		rreg(ASXC_IRQST_ADDR, 8'h01);
		chk(irq, 1'b1);
		wreg(ASXC_IRQCLR_ADDR, 8'h01);
		wait_n(2);
		chk(irq, 1'b0);
		wreg(ASXC_EXT0_ADDR, 8'h40);
		wait_n(2);
		chk(rx_hold_reset, 2'h0);
		dcd_neg <= 1'b0;
		cts_neg <= 1'b1;
		wreg(ASXC_EXT0_ADDR, 8'h00);
		wait_n(6);
		rreg(ASXC_STAT0_ADDR, 8'h00);
		rreg(ASXC_CTLB_ADDR, 8'h40);
		wreg(ASXC_EXT0_ADDR, 8'h20);
		rreg(ASXC_STAT0_ADDR, 8'h02);
		cts_neg <= 1'b0;
		wreg(ASXC_EXT0_ADDR, 8'h00);
		$display("test modem done");
	endtask

	task automatic t_break;
		wreg(ASXC_EXT0_ADDR, 8'h04);
		brk_event(2'h1, 16'h0001);
		rreg(ASXC_EXT0_ADDR, 8'h04);
		brk_event(2'h1, 16'h0000);
		rreg(ASXC_EXT0_ADDR, 8'h06);
		chk(irq, 1'b0);
		wreg(ASXC_CTLA_ADDR, 8'h00);
		rreg(ASXC_EXT0_ADDR, 8'h04);
		wreg(ASXC_EXT1_ADDR, 8'h04);
		brk_event(2'h2, 16'h0000);
		rreg(ASXC_EXT1_ADDR, 8'h06);
		wreg(ASXC_IOCTL_ADDR, 8'h01);
		rreg(ASXC_EXT1_ADDR, 8'h04);
		wreg(ASXC_IOCTL_ADDR, 8'h00);
		wreg(ASXC_EXT0_ADDR, 8'h00);
		brk_event(2'h1, 16'h0000);
		rreg(ASXC_EXT0_ADDR, 8'h00);
		wreg(ASXC_EXT0_ADDR, 8'h05);
		wait_n(2);
		chk(serial_tx_pin, 2'h2);
		wreg(ASXC_EXT0_ADDR, 8'h01);
		wait_n(2);
		chk(serial_tx_pin, 2'h3);
		tx_serial_data <= 1'b0;
		wait_n(3);
		chk(serial_tx_pin, 2'h0);
		tx_serial_data <= 1'b1;
		wreg(ASXC_IRQCLR_ADDR, 8'h07);
		$display("test break done");
	endtask

	task automatic t_baud;
		baud(8'h10, 8'h00, 16'h0000, 18'd10);
		ckpin(18'd10);
		baud(8'h10, 8'h20, 16'h0000, 18'd30);
		baud(8'h10, 8'h01, 16'h0000, 18'd20);
		baud(8'h18, 8'h00, 16'h0001, 18'd6);
		baud(8'h18, 8'h00, 16'h0100, 18'd516);
		ckpin(18'd516);
		baud(8'h08, 8'h00, 16'h0001, 18'd96);
		baud(8'h08, 8'h08, 16'h0001, 18'd384);
		ck_run <= 1'b1;
		baud(8'h10, 8'h07, 16'h0000, 18'd8);
		baud(8'h00, 8'h07, 16'h0000, 18'd128);
		ck_run <= 1'b0;
		$display("test baud done");
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_modem();
		t_break();
		t_baud();
		complete_run();
	end
endmodule
